// File: pkg/vmc_pkg.sv
// Shared constants and carrier types for the volume and silence control block.
// Assumes one 100 MHz clock; sample frames arrive already in that clock domain.
package vmc_pkg;
   // =====================================================================
   // Sizes
   localparam int NCH = 8;
   localparam int SW  = 24;

   // =====================================================================
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CFG  = 8'h06;
   localparam logic [7:0] IDX_GW   = 8'h07;
   localparam logic [7:0] IDX_GQ   = 8'h08;
   localparam logic [7:0] IDX_CW0  = 8'h09;
   localparam logic [7:0] IDX_CW7  = 8'h10;
   localparam logic [7:0] IDX_CQLO = 8'h11;
   localparam logic [7:0] IDX_CQHI = 8'h12;
   localparam logic [7:0] IDX_SIL  = 8'h13;
   localparam logic [7:0] IDX_STAT = 8'h30;

   // =====================================================================
   // Configuration fields and reset values
   localparam int         CFG_SHARED_BIT = 7;
   localparam int         CFG_STYLE_LSB  = 5;
   localparam int         CFG_HOLD_BIT   = 4;
   localparam int         CFG_AUTO_BIT   = 0;
   localparam logic [7:0] CFG_RST        = 8'h41;
   localparam logic [7:0] GAIN_RST       = 8'h00;
   localparam logic [7:0] SIL_RST        = 8'h00;

   // =====================================================================
   // Gain, silence and timing figures
   localparam logic [7:0]  GW_MAX     = 8'h18;
   localparam logic [9:0]  SAT_Q      = 10'h060;
   localparam logic [11:0] FLOOR_LVL  = 12'h800;
   localparam logic [13:0] SIL_RUN    = 14'h2000;
   localparam real         CLK_MHZ    = 100.0;
   localparam real         ZC_TMO_MS  = 18.7;
   localparam int          ZC_TMO_CYC = int'($floor(ZC_TMO_MS * 1000.0 * CLK_MHZ));
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;

   typedef enum logic [1:0] {
      STY_IMM  = 2'h0,
      STY_ZC   = 2'h1,
      STY_RAMP = 2'h2,
      STY_RZC  = 2'h3
   } vmc_style_t;

   // =====================================================================
   // Carriers
   typedef struct packed {
      logic        awvalid;
      logic [11:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [11:0] araddr;
      logic        rready;
   } vmc_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } vmc_axi_rsp_t;

   typedef struct packed {
      logic                   strobe;
      logic [NCH-1:0][SW-1:0] data;
   } vmc_frame_t;

   typedef struct packed {
      logic                   strobe;
      logic [NCH-1:0][SW-1:0] data;
      logic [NCH-1:0][11:0]   level;
      logic [NCH-1:0]         muted;
   } vmc_out_t;

   typedef struct packed {
      logic [7:0]           gw;
      logic [1:0]           gq;
      logic [NCH-1:0][7:0]  cw;
      logic [NCH-1:0][1:0]  cq;
      logic [NCH-1:0]       sil;
   } vmc_set_t;

   typedef struct packed {
      vmc_axi_rsp_t           rsp;
      logic                   aw_held;
      logic                   w_held;
      logic [11:0]            awaddr;
      logic [7:0]             wdata;
      logic                   wstrb0;
      logic [7:0]             cfg;
      vmc_set_t               regs;
      vmc_set_t               app;
      logic [NCH-1:0][13:0]   run;
      logic [NCH-1:0]         auto;
      logic [NCH-1:0]         prev_neg;
      logic [NCH-1:0][20:0]   tmo;
      logic [NCH-1:0][11:0]   level;
      logic [NCH-1:0]         muted;
      logic                   ostb;
      logic [NCH-1:0][SW-1:0] odata;
   } vmc_state_t;
endpackage

// File: core/vmc_top.sv
// Volume and silence control: gain registers, static-run silencing, level stepping.
// Assumes an AXI4-Lite master on mclk and sample frames produced on mclk.
//
// Functional notes
// - With auto-silence on, mute a channel after 8192 consecutive static samples.
// - One non-static sample releases auto-silence and restarts the run count.
// - Static-run detection and silencing run per channel, independently.
// - Auto-silence enable resets to one; zero disables, one enables.
// - Entering and leaving auto-silence follows the selected level-change style.
// - Global whole-dB gain is signed 8-bit, 1 dB steps, applies to all.
// - Whole-dB codes above 24 act as exactly +24 dB, global and per channel.
// - Global quarter-dB field adds 0, 0.25, 0.50 or 0.75 dB.
// - Whole and quarter fields form one signed 10-bit quarter-dB number.
// - Gain changes reach the output through the selected level-change style.
// - Eight per-channel whole-dB gains at indices 09h to 10h, same encoding.
// - Channel quarter fields packed two bits each at indices 11h and 12h.
// - Channel quarter field combines with its whole field as signed quarter-dB.
// - Silence register at 13h, one bit per channel, channel 0 in bit 0.
// - Styles: immediate, zero cross with timeout, ramp per frame, ramp on crossings.
// - Shared gain select makes every channel use channel 0 gain registers.
// - Hold bit freezes applied gains and silence; pending writes land on release.
// - A channel silence bit mutes that channel through the selected style.
`timescale 1ns/1ps
`default_nettype none
module vmc_top #(
   parameter int ZC_TIMEOUT_CYC = vmc_pkg::ZC_TMO_CYC
) (
   // Clock, reset, freeze
   input  wire logic          mclk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   // Register bus
   input  wire vmc_pkg::vmc_axi_req_t axi_req,
   output var  vmc_pkg::vmc_axi_rsp_t axi_rsp,
   // Sample stream
   input  wire vmc_pkg::vmc_frame_t   frame_in,
   output var  vmc_pkg::vmc_out_t     frame_out
);
   import vmc_pkg::*;

   // =====================================================================
   // Elaboration checks
   if (ZC_TIMEOUT_CYC < 1 || ZC_TIMEOUT_CYC >= (1 << 21)) begin : g_chk
      $error("ZC_TIMEOUT_CYC out of range");
   end

   localparam logic [20:0] TMO_LAST = 21'(ZC_TIMEOUT_CYC - 1);

   vmc_state_t               s_q;
   vmc_state_t               s_d;
   logic [NCH-1:0][11:0]     tgt;
   logic [NCH-1:0]           stat;
   logic [NCH-1:0]           zc;
   logic [NCH-1:0]           mact;
   logic [9:0]               gsat;
   vmc_style_t               style;

   // =====================================================================
   // Helpers
   // Saturate a whole:quarter pair to +24 dB, quarter bits dropped then
   function automatic logic [9:0] sat_q(input logic [7:0] w, input logic [1:0] q);
      if ($signed(w) > $signed(GW_MAX)) begin
         return SAT_Q;
      end
      return {w, q};
   endfunction

   // Read decode; flag low marks an unmapped index
   function automatic logic [8:0] rd_word(input vmc_state_t s, input logic [11:0] a);
      logic [7:0] ix;
      logic [8:0] r;
      ix = a[9:2];
      r  = {1'b0, 8'h00};
      if (a[11:10] == 2'h0) begin
         if (ix >= IDX_CW0 && ix <= IDX_CW7) begin
            r = {1'b1, s.regs.cw[3'(ix - IDX_CW0)]};
         end else begin
            unique case (ix)
               IDX_CFG:  r = {1'b1, s.cfg};
               IDX_GW:   r = {1'b1, s.regs.gw};
               IDX_GQ:   r = {1'b1, 6'h00, s.regs.gq};
               IDX_CQLO: r = {1'b1, s.regs.cq[3], s.regs.cq[2], s.regs.cq[1], s.regs.cq[0]};
               IDX_CQHI: r = {1'b1, s.regs.cq[7], s.regs.cq[6], s.regs.cq[5], s.regs.cq[4]};
               IDX_SIL:  r = {1'b1, s.regs.sil};
               IDX_STAT: r = {1'b1, s.auto};
               default:  r = {1'b0, 8'h00};
            endcase
         end
      end
      return r;
   endfunction

   // =====================================================================
   // Per-channel targets and sample classification
   // Targets are in eighth-dB so a ramp step is one count
   always_comb begin
      logic [9:0]  csat;
      logic [10:0] sum;
      int          j;
      csat  = 10'h000;
      sum   = 11'h000;
      j     = 0;
      style = vmc_style_t'(s_q.cfg[CFG_STYLE_LSB +: 2]);
      gsat  = sat_q(s_q.app.gw, s_q.app.gq);
      for (int i = 0; i < NCH; i++) begin
         j = s_q.cfg[CFG_SHARED_BIT] ? 0 : i;
         csat = sat_q(s_q.app.cw[j], s_q.app.cq[j]);
         sum = 11'($signed(gsat)) + 11'($signed(csat));
         mact[i] = s_q.app.sil[i] | (s_q.cfg[CFG_AUTO_BIT] & s_q.auto[i]);
         tgt[i] = mact[i] ? FLOOR_LVL : {sum, 1'b0};
         stat[i] = (frame_in.data[i] == '0) || (frame_in.data[i] == '1);
         zc[i] = frame_in.strobe
               && ((frame_in.data[i] == '0) || (frame_in.data[i][SW-1] != s_q.prev_neg[i]));
      end
   end

   // =====================================================================
   // Next-state logic
   always_comb begin
      logic [7:0]  ix;
      logic [8:0]  rw;
      logic        ok;
      logic [11:0] cur;
      logic [11:0] stp;
      logic        pend;
      logic        ev;
      ix   = 8'h00;
      rw   = 9'h000;
      ok   = 1'b0;
      cur  = 12'h000;
      stp  = 12'h000;
      pend = 1'b0;
      ev   = 1'b0;
      s_d  = s_q;
      if (!rst_n) begin
         // Synchronous reset to constants only
         s_d             = '0;
         s_d.cfg         = CFG_RST;
         s_d.regs.gw     = GAIN_RST;
         s_d.regs.sil    = SIL_RST;
         s_d.app.gw      = GAIN_RST;
         s_d.app.sil     = SIL_RST;
         s_d.rsp.awready = 1'b1;
         s_d.rsp.wready  = 1'b1;
         s_d.rsp.arready = 1'b1;
      end else begin
         // Write address and data are taken independently, in either order
         if (axi_req.awvalid && s_q.rsp.awready) begin
            s_d.aw_held     = 1'b1;
            s_d.awaddr      = axi_req.awaddr;
            s_d.rsp.awready = 1'b0;
         end
         if (axi_req.wvalid && s_q.rsp.wready) begin
            s_d.w_held     = 1'b1;
            s_d.wdata      = axi_req.wdata[7:0];
            s_d.wstrb0     = axi_req.wstrb[0];
            s_d.rsp.wready = 1'b0;
         end
         // Both halves held: commit and answer
         if (s_q.aw_held && s_q.w_held && !s_q.rsp.bvalid) begin
            ix = s_q.awaddr[9:2];
            rw = rd_word(s_q, s_q.awaddr);
            ok = rw[8];
            s_d.aw_held   = 1'b0;
            s_d.w_held    = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp = ok ? RESP_OKAY : RESP_SLV;
            if (ok && s_q.wstrb0) begin
               if (ix >= IDX_CW0 && ix <= IDX_CW7) begin
                  s_d.regs.cw[3'(ix - IDX_CW0)] = s_q.wdata;
               end else begin
                  unique case (ix)
                     IDX_CFG: s_d.cfg = s_q.wdata;
                     IDX_GW:  s_d.regs.gw = s_q.wdata;
                     IDX_GQ:  s_d.regs.gq = s_q.wdata[1:0];
                     IDX_CQLO: begin
                        for (int k = 0; k < 4; k++) begin
                           s_d.regs.cq[k] = s_q.wdata[2*k +: 2];
                        end
                     end
                     IDX_CQHI: begin
                        for (int k = 0; k < 4; k++) begin
                           s_d.regs.cq[k+4] = s_q.wdata[2*k +: 2];
                        end
                     end
                     IDX_SIL: s_d.regs.sil = s_q.wdata;
                     default: s_d.cfg = s_q.cfg; // Status is read-only
                  endcase
               end
            end
         end
         // Ready returns only after the response is taken: one write at a time
         if (s_q.rsp.bvalid && axi_req.bready) begin
            s_d.rsp.bvalid  = 1'b0;
            s_d.rsp.awready = 1'b1;
            s_d.rsp.wready  = 1'b1;
         end
         // Read channel
         if (axi_req.arvalid && s_q.rsp.arready) begin
            rw = rd_word(s_q, axi_req.araddr);
            s_d.rsp.arready = 1'b0;
            s_d.rsp.rvalid  = 1'b1;
            s_d.rsp.rdata   = {24'h000000, rw[7:0]};
            s_d.rsp.rresp   = rw[8] ? RESP_OKAY : RESP_SLV;
         end
         if (s_q.rsp.rvalid && axi_req.rready) begin
            s_d.rsp.rvalid  = 1'b0;
            s_d.rsp.arready = 1'b1;
         end
         // Applied settings follow the registers unless held
         if (!s_q.cfg[CFG_HOLD_BIT]) begin
            s_d.app = s_q.regs;
         end
         // Static-run counting, one counter per channel
         for (int i = 0; i < NCH; i++) begin
            if (frame_in.strobe) begin
               s_d.prev_neg[i] = frame_in.data[i][SW-1];
               if (stat[i]) begin
                  if (s_q.run[i] != SIL_RUN) begin
                     s_d.run[i] = s_q.run[i] + 14'h0001;
                  end
                  if (s_q.run[i] == SIL_RUN - 14'h0001) begin
                     s_d.auto[i] = 1'b1;
                  end
               end else begin
                  s_d.run[i]  = 14'h0000;
                  s_d.auto[i] = 1'b0;
               end
            end
         end
         // Level stepping toward target; silencing uses the same path
         for (int i = 0; i < NCH; i++) begin
            cur  = s_q.level[i];
            pend = (cur != tgt[i]);
            if ($signed(cur) < $signed(tgt[i])) begin
               stp = cur + 12'h001;
            end else if (pend) begin
               stp = cur - 12'h001;
            end else begin
               stp = cur;
            end
            ev = pend && (zc[i] || (s_q.tmo[i] == TMO_LAST));
            unique case (style)
               STY_IMM:  s_d.level[i] = tgt[i];
               STY_ZC:   s_d.level[i] = ev ? tgt[i] : cur;
               STY_RAMP: s_d.level[i] = frame_in.strobe ? stp : cur;
               STY_RZC:  s_d.level[i] = ev ? stp : cur;
            endcase
            // Timeout restarts after each applied change
            s_d.tmo[i]   = (style[0] && pend && !ev) ? s_q.tmo[i] + 21'h000001 : 21'h000000;
            s_d.muted[i] = (s_d.level[i] == FLOOR_LVL);
         end
         // Samples pass through one cycle late, aligned with levels
         s_d.ostb = frame_in.strobe;
         if (frame_in.strobe) begin
            s_d.odata = frame_in.data;
         end
      end
   end

   // =====================================================================
   // State register; ce low freezes everything except reset
   always_ff @(posedge mclk) begin
      if (!rst_n || ce) begin
         s_q <= s_d;
      end
   end

   // Outputs straight from state
   assign axi_rsp          = s_q.rsp;
   assign frame_out.strobe = s_q.ostb;
   assign frame_out.data   = s_q.odata;
   assign frame_out.level  = s_q.level;
   assign frame_out.muted  = s_q.muted;

   // =====================================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence seq_wr_take;
      ce && axi_req.awvalid && s_q.rsp.awready && axi_req.wvalid && s_q.rsp.wready;
   endsequence

   sequence seq_static_last;
      ce && frame_in.strobe && stat[0] && (s_q.run[0] == SIL_RUN - 14'h0001);
   endsequence

   chk_run_mute: assert property (seq_static_last |=> s_q.auto[0] && s_q.run[0] == SIL_RUN)
      else $error("static run did not raise auto silence");
   chk_run_release: assert property (ce && frame_in.strobe && !stat[1] |=>
      !s_q.auto[1] && s_q.run[1] == 14'h0000)
      else $error("non-static sample did not release");
   chk_auto_reset: assert property ($rose(rst_n) |-> s_q.cfg[CFG_AUTO_BIT] && !s_q.auto[2])
      else $error("auto silence enable not set after reset");
   chk_sat_whole: assert property ($signed(s_q.app.gw) > $signed(GW_MAX) |-> gsat == SAT_Q)
      else $error("whole gain not saturated");
   chk_imm_level: assert property (ce && style == STY_IMM |=> s_q.level[3] == $past(tgt[3]))
      else $error("immediate style did not apply target");
   chk_ramp_step: assert property (ce && style == STY_RAMP |=>
      (12'(s_q.level[4] - $past(s_q.level[4])) inside {12'h000, 12'h001, 12'hFFF}))
      else $error("ramp moved more than one step");
   chk_hold_keep: assert property (ce && s_q.cfg[CFG_HOLD_BIT] |=> s_q.app == $past(s_q.app))
      else $error("held settings changed");
   chk_write_resp: assert property (seq_wr_take ##1 ce |=> s_q.rsp.bvalid)
      else $error("write not answered");
   chk_mute_imm: assert property (ce && style == STY_IMM && s_q.app.sil[0] |=> s_q.muted[0])
      else $error("silence bit did not mute");
   chk_shared_gain: assert property (s_q.cfg[CFG_SHARED_BIT] && !mact[5] && !mact[6]
      |-> tgt[6] == tgt[5])
      else $error("shared gain not used");
endmodule
`default_nettype wire

// File: verif/vmc_host.sv
// Host model: an AXI4-Lite master that writes and reads the gain registers.
// Assumes a slave clocked by mclk; one caller at a time uses each task.
`timescale 1ns/1ps
`default_nettype none
module vmc_host (
   // Clock
   input  wire logic                  mclk,
   // Register bus
   output var  vmc_pkg::vmc_axi_req_t axi_req,
   input  wire vmc_pkg::vmc_axi_rsp_t axi_rsp
);
   import vmc_pkg::*;

   // ========
   // Bus idle from time zero
   initial begin
      axi_req = '0;
   end

   // Address and data go out together, each dropped on its own take
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
      logic a;
      logic w;
      a = 1'b0;
      w = 1'b0;
      @(posedge mclk);
      axi_req.awaddr  <= {2'h0, idx, 2'h0};
      axi_req.wdata   <= {24'h0, d};
      axi_req.wstrb   <= 4'hF;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid  <= 1'b1;
      axi_req.bready  <= 1'b1;
      while (!(a && w)) begin
         @(posedge mclk);
         if (!a && axi_rsp.awready) begin
            a = 1'b1;
            axi_req.awvalid <= 1'b0;
         end
         if (!w && axi_rsp.wready) begin
            w = 1'b1;
            axi_req.wvalid <= 1'b0;
         end
      end
      // Ready stays up until the answer is seen, however late
      do @(posedge mclk); while (axi_rsp.bvalid !== 1'b1);
      resp = axi_rsp.bresp;
      axi_req.bready <= 1'b0;
   endtask

   // Read: data and response taken at the rvalid edge
   task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
      @(posedge mclk);
      axi_req.araddr  <= {2'h0, idx, 2'h0};
      axi_req.arvalid <= 1'b1;
      axi_req.rready  <= 1'b1;
      do @(posedge mclk); while (axi_rsp.arready !== 1'b1);
      axi_req.arvalid <= 1'b0;
      do @(posedge mclk); while (axi_rsp.rvalid !== 1'b1);
      d = axi_rsp.rdata;
      resp = axi_rsp.rresp;
      axi_req.rready <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: verif/volume_mute_control_test.sv
// Self-checking bench for the volume and silence block.
// Assumes the host model drives the register bus; frames come from this bench.
`timescale 1ns/1ps
`default_nettype none
module volume_mute_control_test;
   import vmc_pkg::*;
   logic                   mclk;
   logic                   rst_n;
   logic                   ce;
   vmc_axi_req_t           axi_req;
   vmc_axi_rsp_t           axi_rsp;
   vmc_frame_t             frame_in;
   vmc_out_t               frame_out;
   int                     fail_count = 0;
   int                     cmp_count = 0;
   int                     seed = 81922;
   int                     cycles;
   logic [1:0]             r;
   logic [31:0]            rdv;
   logic [7:0]             w;
   logic [7:0]             cw;
   logic [2:0]             k;
   logic [11:0]            e;
   logic [7:0]             cw_sh [NCH];
   logic [NCH-1:0][1:0]    cq_sh;
   logic [1:0]             gq_sh;
   logic [NCH-1:0][SW-1:0] d;
   logic [7:0]             corner [6] = '{8'h18, 8'h19, 8'h7F, 8'h80, 8'h81, 8'hFF};
   logic [7:0]             rst_idx [8] = '{IDX_CFG, IDX_GW, IDX_GQ, IDX_CW0, IDX_CW7,
                                           IDX_CQLO, IDX_CQHI, IDX_SIL};

   // ========
   // Design, short zero-cross timeout to keep the run brief
   vmc_top #(.ZC_TIMEOUT_CYC(50)) uut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .axi_req(axi_req),
      .axi_rsp(axi_rsp), .frame_in(frame_in), .frame_out(frame_out));
   vmc_host host (.mclk(mclk), .axi_req(axi_req), .axi_rsp(axi_rsp));

   // 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ========
   // Checking and verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Hang guard, well above the expected run length
   initial begin
      cycles = 0;
      forever begin
         @(posedge mclk);
         cycles++;
         if (cycles == 30000) begin
            fail_count++;
            print_verdict();
         end
      end
   end

   // ========
   // Expected gains in quarter dB, saturation ignores the quarter bits
   function automatic int sq(input logic [7:0] wh, input logic [1:0] q);
      if ($signed(wh) > 8'sh18)
         return 96;
      return $signed({wh, q});
   endfunction

   function automatic logic [11:0] tgt(input logic [7:0] a, input logic [1:0] aq,
                                       input logic [7:0] b, input logic [1:0] bq);
      return 12'(2 * (sq(a, aq) + sq(b, bq)));
   endfunction

   // ========
   // Stimulus helpers
   // Ends mid-cycle so outputs are looked at where they are settled
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic wrr(input logic [7:0] idx, input logic [7:0] v);
      host.wr(idx, v, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [7:0] v);
      host.rd(idx, rdv, r);
      chk(rdv, {24'h0, v});
   endtask

   task automatic lvl(input int c, input logic [11:0] v);
      chk({20'h0, frame_out.level[c]}, {20'h0, v});
   endtask

   // Strobe held high for n back-to-back frames
   task automatic burst(input int n);
      @(posedge mclk);
      frame_in.data   <= d;
      frame_in.strobe <= 1'b1;
      repeat (n) @(posedge mclk);
      frame_in.strobe <= 1'b0;
      // Last frame echoed one cycle late, looked at mid-cycle
      @(negedge mclk);
      chk({31'h0, frame_out.strobe}, 32'h1);
      chk({8'h0, frame_out.data[7]}, {8'h0, d[7]});
   endtask

   // ========
   // Main sequence
   initial begin
      ce = 1'b1;
      rst_n = 1'b0;
      frame_in = '0;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++)
         rdc(rst_idx[i], (i == 0) ? CFG_RST : GAIN_RST);
      host.rd(8'h2F, rdv, r);
      chk({30'h0, r}, {30'h0, RESP_SLV});
      host.wr(8'h14, 8'h5A, r);
      chk({30'h0, r}, {30'h0, RESP_SLV});
      // Static runs: zeros on 0, minus one on 1, live data elsewhere
      wrr(IDX_CFG, 8'h01);
      d[0] = 24'h0;
      d[1] = 24'hFFFFFF;
      for (int c = 2; c < NCH; c++)
         d[c] = {1'b0, 22'($random(seed)), 1'b1};
      burst(8191);
      tick(3);
      chk({24'h0, frame_out.muted}, 32'h00);
      burst(1);
      tick(3);
      chk({24'h0, frame_out.muted}, 32'h03);
      rdc(IDX_STAT, 8'h03);
      d[0] = 24'h000005;
      burst(1);
      tick(3);
      chk({24'h0, frame_out.muted}, 32'h02);
      wrr(IDX_CFG, 8'h00);
      tick(3);
      chk({24'h0, frame_out.muted}, 32'h00);
      rdc(IDX_STAT, 8'h02);
      // Soft ramp: one eighth-dB step per frame, silencing too
      wrr(IDX_CFG, 8'h41);
      for (int c = 0; c < NCH; c++)
         d[c] = 24'h000010;
      wrr(IDX_GW, 8'h01);
      burst(3);
      tick(3);
      lvl(0, 12'h003);
      wrr(IDX_SIL, 8'h04);
      burst(2);
      tick(3);
      lvl(0, 12'h005);
      lvl(2, 12'h001);
      // Frames offered while the enable is low must not step anything
      @(posedge mclk);
      ce              <= 1'b0;
      frame_in.strobe <= 1'b1;
      repeat (3) @(posedge mclk);
      ce              <= 1'b1;
      frame_in.strobe <= 1'b0;
      tick(2);
      lvl(0, 12'h005);
      lvl(2, 12'h001);
      burst(10);
      tick(3);
      lvl(0, 12'h008);
      // Zero cross: timeout first, then a sign change
      wrr(IDX_CFG, 8'h21);
      wrr(IDX_GW, 8'h02);
      tick(60);
      lvl(0, 12'h010);
      for (int c = 0; c < NCH; c++)
         d[c] = 24'hFFFF00;
      wrr(IDX_GW, 8'h03);
      burst(1);
      tick(3);
      lvl(0, 12'h018);
      // Ramp on crossings: one step per crossing
      wrr(IDX_CFG, 8'h61);
      wrr(IDX_GW, 8'h04);
      for (int c = 0; c < NCH; c++)
         d[c] = 24'h000020;
      burst(1);
      tick(3);
      lvl(0, 12'h019);
      // Hold keeps old settings until released
      wrr(IDX_CFG, 8'h11);
      wrr(IDX_GW, 8'h05);
      wrr(IDX_SIL, 8'h01);
      tick(3);
      lvl(1, 12'h020);
      chk({24'h0, frame_out.muted}, 32'h04);
      wrr(IDX_CFG, 8'h01);
      tick(3);
      lvl(1, 12'h028);
      chk({24'h0, frame_out.muted}, 32'h01);
      // Shared select takes channel 0 gain for all
      wrr(IDX_CW0 + 8'h05, 8'h10);
      wrr(IDX_CFG, 8'h81);
      wrr(IDX_CW0, 8'h02);
      tick(3);
      lvl(5, 12'h038);
      lvl(6, 12'h038);
      // Random gains with corner codes first
      wrr(IDX_CFG, 8'h01);
      wrr(IDX_SIL, 8'h00);
      for (int c = 0; c < NCH; c++) begin
         wrr(IDX_CW0 + 8'(c), 8'h00);
         cw_sh[c] = 8'h00;
      end
      cq_sh = '0;
      for (int i = 0; i < 14; i++) begin
         w = (i < 6) ? corner[i] : 8'($random(seed));
         cw = (i < 6) ? corner[5-i] : 8'($random(seed));
         k = 3'($random(seed));
         gq_sh = 2'($random(seed));
         cq_sh[k] = 2'($random(seed));
         cw_sh[k] = cw;
         wrr(IDX_GW, w);
         wrr(IDX_GQ, {6'h0, gq_sh});
         wrr(IDX_CW0 + {5'h0, k}, cw);
         wrr(IDX_CQLO, cq_sh[3:0]);
         wrr(IDX_CQHI, cq_sh[7:4]);
         tick(3);
         for (int c = 0; c < NCH; c++) begin
            e = tgt(w, gq_sh, cw_sh[c], cq_sh[c]);
            lvl(c, e);
            chk({31'h0, frame_out.muted[c]}, {31'h0, e == FLOOR_LVL});
         end
         rdc(IDX_CW0 + {5'h0, k}, cw);
         rdc(IDX_CQLO, cq_sh[3:0]);
         rdc(IDX_CQHI, cq_sh[7:4]);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
